// [rtl/gated_timer_consts.vh]
/*
  Constants for the gated sixteen-bit timer: register offsets, field
  positions, reset values and source encodings.
  Assumes a Wishbone slave with 32-bit data, one register per word.
*/
// Contract
// - Select 00 counts once per instruction cycle, a quarter of the clock.
// - Select 01 counts every system clock.
// - Select 10 counts pin rising edges after first fall, or oscillator.
// - Wide mode: low-byte read copies high byte into holding buffer.
// - Wide mode: high writes go to buffer; low write loads high byte.
// - Wide mode: live high byte never reached directly.
// - Low-byte write clears prescaler; high-byte write does not.
// - Oscillator enabled by either enable bit, warm-up bit or clock select 01.
// - Gate enabled: count only while gate active, else hold.
// - Gate active when gate level equals polarity bit.
// - Gate source: 00 pin, 01 match pulse, 10 comp one, 11 comp two.
// - Companion rollover after period match gives one-cycle gate pulse.
// - Match gate: polarity 1 counts that cycle only, 0 all but it.
// - Comparator gate from status bit 6 or bit 7.
// - Toggle mode: gate through flip-flop changing on each rising edge of the polarised gate.
// - Toggle bit zero clears and holds the toggle flip-flop.
// - Gate level status shows effective gate after toggling.
// - Status bit 6 reads 1 when system clock is secondary oscillator.
// - Drive bit 4 resets to 1, selects high-power oscillator circuit.
// - Warm-up bit 3 keeps oscillator running without requester.
// - Bit 0 substitutes medium oscillator; bit 1 reads medium stable.
// - External edge detector frozen in Sleep unless sync bypass set; synchronisers keep running.
// - Count wraps FFFFh to 0000h and sets overflow flag.
// - Sync bypass bit set keeps external counting running in Sleep; the source is still sampled on the block clock.
`ifndef GATED_TIMER_CONSTS_VH
`define GATED_TIMER_CONSTS_VH
`define ADR_CONTROL      4'h0
`define ADR_GATE_CONTROL 4'h1
`define ADR_COUNT_LOW    4'h2
`define ADR_COUNT_HIGH   4'h3
`define ADR_OSC_CONTROL  4'h4
`define ADR_STATUS       4'h5
`define ADR_COMPANION    4'h6
`define CTL_RESET        8'h00
`define GCON_RESET       8'h00
`define OSC2_RESET       8'h10
`define CTL_ON           0
`define CTL_WIDE         1
`define CTL_SYNC_BYPASS  2
`define CTL_OSC_ENABLE   3
`define GC_ENABLE        7
`define GC_POLARITY      6
`define GC_TOGGLE        5
`define GC_LEVEL         2
`define OSC2_CLK_ACTIVE  6
`define OSC2_DRIVE       4
`define OSC2_WARMUP      3
`define OSC2_MED_STABLE  1
`define OSC2_MED_SUB     0
`define CLKSEL_INSTR     2'h0
`define CLKSEL_SYSTEM    2'h1
`define CLKSEL_EXTERNAL  2'h2
`define GSRC_PIN         2'h0
`define GSRC_MATCH       2'h1
`define GSRC_COMP_ONE    2'h2
`define GSRC_COMP_TWO    2'h3
`define SYSCLK_SECONDARY 2'h1
`define INSTR_DIV        2'h3
`define COMPANION_PERIOD_RESET 8'hff
`endif

// [rtl/level_sync.v]
/*
  Two-flop synchroniser for one asynchronous level.
  Assumes clk_i is the block clock; the first flop feeds only the second.
*/
`timescale 1ns/10ps
module level_sync (
  input  wire clk_i,
  input  wire rst_i,
  input  wire async_i,
  output reg  sync_o
);
  reg first;

  always @(posedge clk_i) begin
    if (rst_i) begin
      first  <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      first  <= async_i;
      sync_o <= first;
    end
  end
endmodule

// [rtl/gated_sixteen_bit_timer.v]
/*
  Gated sixteen-bit timer with companion eight-bit period timer, secondary
  oscillator request logic and a classic Wishbone slave.
  Assumes pins are asynchronous to clk_i; the external count pin is
  sampled, so its edges must be slower than half the clock rate.
*/
`timescale 1ns/10ps
`include "gated_timer_consts.vh"
module gated_sixteen_bit_timer (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [3:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  input  wire        external_count_pin_i,
  input  wire        secondary_oscillator_i,
  input  wire        gate_pin_i,
  input  wire        comparator_one_status_i,
  input  wire        comparator_two_status_i,
  input  wire        other_timer_osc_enable_i,
  input  wire [1:0]  system_clock_select_i,
  input  wire        medium_osc_stable_i,
  input  wire        sleep_i,
  output reg         secondary_osc_enable_o,
  output reg         secondary_osc_drive_o,
  output reg         medium_osc_substitute_o,
  output reg         overflow_flag_o,
  output reg         gate_level_status_o,
  output reg  [15:0] count_o
);
  reg  [7:0]  control;
  reg  [7:0]  gate_control;
  reg  [7:0]  osc_control;
  reg  [7:0]  companion_period;
  reg  [7:0]  companion_timer_count;
  reg  [7:0]  high_buffer;
  reg  [15:0] count;
  reg  [2:0]  prescaler;
  reg  [1:0]  instr_phase;
  reg         match_pulse;
  reg         toggle_ff;
  reg         ext_prev;
  reg         ext_armed;
  reg         gate_prev_src;
  reg         overflow_flag;
  reg  [31:0] next_dat;

  wire        pin_sync;
  wire        osc_sync;
  wire        gate_pin_sync;
  wire        comp_one_sync;
  wire        comp_two_sync;

  level_sync u_sync_pin (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (external_count_pin_i),
    .sync_o  (pin_sync)
  );
  level_sync u_sync_osc (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (secondary_oscillator_i),
    .sync_o  (osc_sync)
  );
  level_sync u_sync_gate (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (gate_pin_i),
    .sync_o  (gate_pin_sync)
  );
  level_sync u_sync_c1 (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (comparator_one_status_i),
    .sync_o  (comp_one_sync)
  );
  level_sync u_sync_c2 (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (comparator_two_status_i),
    .sync_o  (comp_two_sync)
  );

  wire [1:0] clk_sel   = control[7:6];
  wire [1:0] presc_sel = control[5:4];
  wire       wide      = control[`CTL_WIDE];
  wire [1:0] gate_src  = gate_control[1:0];

  wire access  = cyc_i & stb_i & ~ack_o;
  wire wr_low  = access & we_i & sel_i[0] & (adr_i == `ADR_COUNT_LOW);
  wire wr_high = access & we_i & sel_i[0] & (adr_i == `ADR_COUNT_HIGH);
  wire rd_low  = access & ~we_i & (adr_i == `ADR_COUNT_LOW);

  wire instr_tick = (instr_phase == `INSTR_DIV);

  // The pin and oscillator are sampled on the block clock; in Sleep the
  // external edge detector is frozen unless the sync bypass bit is set.
  wire ext_src  = control[`CTL_OSC_ENABLE] ? osc_sync : pin_sync;
  wire ext_rise = ext_src & ~ext_prev & ext_armed;
  wire ext_tick = ext_rise &
                  (control[`CTL_SYNC_BYPASS] | ~sleep_i);

  reg src_tick;
  always @* begin
    case (clk_sel)
      `CLKSEL_INSTR:    src_tick = instr_tick;
      `CLKSEL_SYSTEM:   src_tick = 1'b1;
      `CLKSEL_EXTERNAL: src_tick = ext_tick;
      default:          src_tick = 1'b0;
    endcase
  end

  reg gate_raw;
  always @* begin
    case (gate_src)
      `GSRC_PIN:      gate_raw = gate_pin_sync;
      `GSRC_MATCH:    gate_raw = match_pulse;
      `GSRC_COMP_ONE: gate_raw = comp_one_sync;
      `GSRC_COMP_TWO: gate_raw = comp_two_sync;
      default:        gate_raw = 1'b0;
    endcase
  end

  wire gate_polar = ~(gate_raw ^ gate_control[`GC_POLARITY]);
  wire gate_eff   = gate_control[`GC_TOGGLE] ? toggle_ff
                                             : gate_polar;
  wire gate_ok    = ~gate_control[`GC_ENABLE] | gate_eff;

  reg presc_done;
  always @* begin
    case (presc_sel)
      2'h0:    presc_done = 1'b1;
      2'h1:    presc_done = prescaler[0];
      2'h2:    presc_done = &prescaler[1:0];
      default: presc_done = &prescaler;
    endcase
  end

  wire run      = control[`CTL_ON] & src_tick & gate_ok;
  wire inc      = run & presc_done;
  wire wrap     = inc & (count == 16'hffff);
  wire comp_hit = instr_tick & (companion_timer_count == companion_period);

  always @(posedge clk_i) begin
    if (rst_i) begin
      instr_phase           <= 2'h0;
      companion_timer_count <= 8'h00;
      match_pulse           <= 1'b0;
      ext_prev              <= 1'b0;
      ext_armed             <= 1'b0;
      gate_prev_src         <= 1'b0;
      toggle_ff             <= 1'b0;
    end else begin
      instr_phase <= instr_phase + 2'h1;
      if (instr_tick)
        companion_timer_count <= comp_hit ? 8'h00
                                          : companion_timer_count + 8'h01;
      // Pulse lasts one instruction cycle after the roll to zero.
      if (instr_tick)
        match_pulse <= comp_hit;
      if (~sleep_i | control[`CTL_SYNC_BYPASS]) begin
        ext_prev <= ext_src;
        if (~ext_src)
          ext_armed <= 1'b1;
      end
      if (clk_sel != `CLKSEL_EXTERNAL)
        ext_armed <= 1'b0;
      gate_prev_src <= gate_polar;
      if (~gate_control[`GC_TOGGLE])
        toggle_ff <= 1'b0;
      else if (gate_polar & ~gate_prev_src)
        toggle_ff <= ~toggle_ff;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      count         <= 16'h0000;
      prescaler     <= 3'h0;
      overflow_flag <= 1'b0;
      high_buffer   <= 8'h00;
    end else begin
      if (wr_low) begin
        prescaler <= 3'h0;
        count[7:0] <= dat_i[7:0];
        if (wide)
          count[15:8] <= high_buffer;
      end else if (wr_high & ~wide) begin
        count[15:8] <= dat_i[7:0];
      end else if (inc) begin
        count <= count + 16'h0001;
      end
      if (run & ~wr_low)
        prescaler <= presc_done ? 3'h0 : prescaler + 3'h1;
      if (wr_high & wide)
        high_buffer <= dat_i[7:0];
      else if (rd_low & wide)
        high_buffer <= count[15:8];
      if (wrap)
        overflow_flag <= 1'b1;
      else if (access & we_i & sel_i[0] & (adr_i == `ADR_STATUS) &
               dat_i[0])
        overflow_flag <= 1'b0;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      control          <= `CTL_RESET;
      gate_control     <= `GCON_RESET;
      osc_control      <= `OSC2_RESET;
      companion_period <= `COMPANION_PERIOD_RESET;
    end else if (access & we_i & sel_i[0]) begin
      case (adr_i)
        `ADR_CONTROL:      control <= dat_i[7:0];
        `ADR_GATE_CONTROL: gate_control <= {dat_i[7:3], 1'b0, dat_i[1:0]};
        `ADR_OSC_CONTROL:  osc_control <= {3'h0, dat_i[4:3], 2'h0,
                                           dat_i[0]};
        `ADR_COMPANION:    companion_period <= dat_i[7:0];
        default:           ;
      endcase
    end
  end

  always @* begin
    next_dat = 32'h0000_0000;
    case (adr_i)
      `ADR_CONTROL:      next_dat[7:0] = control;
      `ADR_GATE_CONTROL: next_dat[7:0] = {gate_control[7:3], gate_eff,
                                          gate_control[1:0]};
      `ADR_COUNT_LOW:    next_dat[7:0] = count[7:0];
      `ADR_COUNT_HIGH:   next_dat[7:0] = wide ? high_buffer
                                              : count[15:8];
      `ADR_OSC_CONTROL:  next_dat[7:0] = {1'b0,
                         system_clock_select_i == `SYSCLK_SECONDARY,
                         1'b0, osc_control[`OSC2_DRIVE],
                         osc_control[`OSC2_WARMUP], 1'b0,
                         medium_osc_stable_i,
                         osc_control[`OSC2_MED_SUB]};
      `ADR_STATUS:       next_dat[0] = overflow_flag;
      `ADR_COMPANION:    next_dat[15:0] = {companion_timer_count,
                                           companion_period};
      default:           next_dat = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o                   <= 1'b0;
      dat_o                   <= 32'h0000_0000;
      secondary_osc_enable_o  <= 1'b0;
      secondary_osc_drive_o   <= 1'b1;
      medium_osc_substitute_o <= 1'b0;
      overflow_flag_o         <= 1'b0;
      gate_level_status_o     <= 1'b0;
      count_o                 <= 16'h0000;
    end else begin
      ack_o <= access;
      if (access & ~we_i)
        dat_o <= next_dat;
      secondary_osc_enable_o  <= control[`CTL_OSC_ENABLE] |
                                 other_timer_osc_enable_i |
                                 osc_control[`OSC2_WARMUP] |
                                 (system_clock_select_i ==
                                  `SYSCLK_SECONDARY);
      secondary_osc_drive_o   <= osc_control[`OSC2_DRIVE];
      medium_osc_substitute_o <= osc_control[`OSC2_MED_SUB];
      overflow_flag_o         <= overflow_flag;
      gate_level_status_o     <= gate_eff;
      count_o                 <= count;
    end
  end
endmodule

// [testbench/pin_source.sv]
/*
  Far-side source for the timer: external count pin and oscillator.
  Assumes the bench calls pulses(); edges stay slow against the clock.
*/
`timescale 1ns/10ps
module pin_source (
  input  wire clk_i,
  output reg  count_pin_o,
  output reg  osc_o
);
  // The pin idles high so a first rise before any fall would be spurious.
  initial begin
    count_pin_o = 1'b1;
    osc_o = 1'b0;
  end
  // The oscillator idles low, so its first rise is a genuine edge.
  task pulses(input integer n, input osel);
    repeat (n) begin
      repeat (4) @(posedge clk_i);
      if (osel)
        osc_o <= 1'b1;
      else
        count_pin_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      if (osel)
        osc_o <= 1'b0;
      else
        count_pin_o <= 1'b1;
    end
  endtask
endmodule

// [testbench/gated_sixteen_bit_timer_assertions.sv]
/*
  Checker for the gated timer: bus answer, count steps, overflow, osc.
  Assumes it is bound to the timer top and sees only its ports.
*/
`timescale 1ns/10ps
module gated_timer_checker (
  input wire        clk_i,
  input wire        rst_i,
  input wire        cyc_i,
  input wire        stb_i,
  input wire        we_i,
  input wire [3:0]  adr_i,
  input wire [31:0] dat_o,
  input wire        ack_o,
  input wire        other_timer_osc_enable_i,
  input wire [1:0]  system_clock_select_i,
  input wire        secondary_osc_enable_o,
  input wire        secondary_osc_drive_o,
  input wire        overflow_flag_o,
  input wire        gate_level_status_o,
  input wire [15:0] count_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire      wr = cyc_i & stb_i & we_i;
  reg [2:0] wr_hist;
  // Writes show on count_o up to three edges later, so steps skip them.
  always @(posedge clk_i) begin
    if (rst_i)
      wr_hist <= 3'h0;
    else
      wr_hist <= {wr_hist[1:0], wr};
  end
  property p_ack_pulse; ack_o |=> !ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
  property p_ack_next; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack");
  property p_unmapped;
    cyc_i && stb_i && !we_i && !ack_o && adr_i > 4'h6 |=> dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped data");
  property p_count_step;
    wr_hist == 3'h0 && $changed(count_o) |->
      count_o == $past(count_o) + 16'h1;
  endproperty
  a_count_step: assert property (p_count_step) else $error("count jump");
  property p_wrap_flag;
    wr_hist == 3'h0 && $past(count_o) == 16'hffff && count_o == 16'h0
      |-> ##[0:2] overflow_flag_o;
  endproperty
  a_wrap_flag: assert property (p_wrap_flag) else $error("no flag");
  property p_flag_sticky;
    overflow_flag_o && !(wr && adr_i == 4'h5) |=> overflow_flag_o;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");
  property p_drive_hold;
    !(wr && adr_i == 4'h4) |=> $stable(secondary_osc_drive_o);
  endproperty
  a_drive_hold: assert property (p_drive_hold) else $error("drive moved");
  property p_osc_request;
    other_timer_osc_enable_i || system_clock_select_i == 2'h1
      |-> ##[1:2] secondary_osc_enable_o;
  endproperty
  a_osc_request: assert property (p_osc_request) else $error("osc off");
  c_overflow: cover property (overflow_flag_o);
  c_gate_rise: cover property ($rose(gate_level_status_o));
  c_read: cover property (ack_o && !we_i);
endmodule
bind gated_sixteen_bit_timer gated_timer_checker u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
  .other_timer_osc_enable_i(other_timer_osc_enable_i),
  .system_clock_select_i(system_clock_select_i),
  .secondary_osc_enable_o(secondary_osc_enable_o),
  .secondary_osc_drive_o(secondary_osc_drive_o),
  .overflow_flag_o(overflow_flag_o),
  .gate_level_status_o(gate_level_status_o), .count_o(count_o));

// [testbench/gated_sixteen_bit_timer_tb.sv]
/*
  Bench for the gated timer: Wishbone tasks and count-window checks.
  Assumes the constants header and a one-cycle Wishbone answer.
*/
`timescale 1ns/10ps
`include "gated_timer_consts.vh"
module gated_sixteen_bit_timer_tb;
  reg         clk_i, rst_i, cyc_i, stb_i, we_i, gpin, lvl_c, oth, mstb;
  reg         lvl_d, slp;
  reg  [3:0]  adr_i;
  reg  [31:0] dat_i, rdata;
  reg  [1:0]  ssel;
  reg  [15:0] c0;
  wire [31:0] dat_o;
  wire        ack_o, xpin, osc, osc_en, drv, sub, ovf, gval;
  wire [15:0] count_o;
  integer     fail_count, n_compared, s, p, l;
  pin_source src (.clk_i(clk_i), .count_pin_o(xpin), .osc_o(osc));
  gated_sixteen_bit_timer dut (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .external_count_pin_i(xpin), .secondary_oscillator_i(osc),
    .gate_pin_i(gpin), .comparator_one_status_i(lvl_c),
    .comparator_two_status_i(lvl_d), .other_timer_osc_enable_i(oth),
    .system_clock_select_i(ssel), .medium_osc_stable_i(mstb),
    .sleep_i(slp), .secondary_osc_enable_o(osc_en),
    .secondary_osc_drive_o(drv), .medium_osc_substitute_o(sub),
    .overflow_flag_o(ovf), .gate_level_status_o(gval), .count_o(count_o));
  task check(input string name, input [31:0] exp, input [31:0] got);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("wrong value %0s expected %h seen %h", name, exp, got);
    end
  endtask
  // Only the watchdog ends a wait for the answer.
  task bus(input w, input [3:0] a, input [31:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
    @(posedge clk_i);
    while (ack_o !== 1'b1)
      @(posedge clk_i);
    check("ack", 1, ack_o);
    rdata = dat_o;
    {cyc_i, stb_i} <= 2'b00;
  endtask
  task rd(input [3:0] a, input [31:0] exp, input string name);
    bus(1'b0, a, 32'h0);
    check(name, exp, rdata);
  endtask
  task win(input integer n, input [31:0] exp, input string name);
    repeat (4) @(negedge clk_i);
    c0 = count_o;
    repeat (n) @(negedge clk_i);
    c0 = count_o - c0;
    check(name, exp, {16'h0, c0});
    @(posedge clk_i);
  endtask
  // Counts seen over n far-side pulses; the tail covers sync latency.
  task pcount(input integer n, input osel, input [31:0] exp,
              input string name);
    c0 = count_o;
    src.pulses(n, osel);
    repeat (6) @(negedge clk_i);
    check(name, exp, {16'h0, count_o - c0});
    @(posedge clk_i);
  endtask
  task gpulse;
    @(posedge clk_i);
    gpin <= 1'b1;
    repeat (4) @(posedge clk_i);
    gpin <= 1'b0;
  endtask
  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Generous bound: the full sequence needs well under 10000 cycles.
  initial begin
    repeat (30000) @(posedge clk_i);
    fail_count = fail_count + 1;
    report_and_stop;
  end
  initial begin
    {rst_i, cyc_i, stb_i, we_i, gpin, lvl_c, oth, mstb} = 8'h80;
    {adr_i, dat_i, ssel} = 38'h0;
    {lvl_d, slp} = 2'b00;
    fail_count = 0;
    n_compared = 0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    // Set the period while the companion count is still below it.
    bus(1, `ADR_COMPANION, 32'h3);
    rd(`ADR_OSC_CONTROL, 32'h10, "osc reset");
    rd(`ADR_CONTROL, 32'h0, "control reset");
    rd(4'hf, 32'h0, "unmapped");
    $display("test reset done");
    bus(1, `ADR_CONTROL, 32'h01);
    win(40, 10, "instr count");
    bus(1, `ADR_CONTROL, 32'h41);
    win(40, 40, "system count");
    bus(1, `ADR_CONTROL, 32'h71);
    win(80, 10, "prescaled count");
    bus(1, `ADR_CONTROL, 32'h81);
    pcount(5, 1'b0, 5, "pin count");
    bus(1, `ADR_CONTROL, 32'h85);
    slp <= 1'b1;
    pcount(3, 1'b0, 3, "sleep bypass");
    bus(1, `ADR_CONTROL, 32'h81);
    pcount(3, 1'b0, 0, "sleep frozen");
    bus(1, `ADR_CONTROL, 32'h89);
    slp <= 1'b0;
    pcount(3, 1'b1, 3, "osc count");
    pcount(2, 1'b0, 0, "pin ignored");
    $display("test clock sources done");
    bus(1, `ADR_CONTROL, 32'h41);
    for (s = 0; s < 4; s = s + 1)
      for (p = 0; p < 2; p = p + 1)
        for (l = 0; l < 2; l = l + 1) begin
          // Unselected level sources show the opposite level.
          {gpin, lvl_c, lvl_d} <= {l[0] ^ (s != 0), l[0] ^ (s != 2),
                                   l[0] ^ (s != 3)};
          bus(1, `ADR_GATE_CONTROL, {24'h0, 1'b1, p[0], 4'h0, s[1:0]});
          win(160, s == 1 ? (p ? 40 : 120) : (p == l ? 160 : 0),
              "gated count");
        end
    gpin <= 1'b0;
    bus(1, `ADR_GATE_CONTROL, 32'he0);
    win(40, 0, "toggle idle");
    gpulse;
    win(40, 40, "toggle open");
    check("gate status", 1, gval);
    bus(1, `ADR_GATE_CONTROL, 32'hc0);
    bus(1, `ADR_GATE_CONTROL, 32'he0);
    win(40, 0, "toggle cleared");
    check("gate status off", 0, gval);
    gpulse;
    gpulse;
    win(40, 0, "toggle shut");
    $display("test gates done");
    bus(1, `ADR_GATE_CONTROL, 32'h0);
    bus(1, `ADR_CONTROL, 32'h0);
    bus(1, `ADR_COUNT_HIGH, 32'hab);
    bus(1, `ADR_COUNT_LOW, 32'h0);
    rd(`ADR_COUNT_HIGH, 32'hab, "narrow high");
    bus(1, `ADR_CONTROL, 32'h2);
    bus(1, `ADR_COUNT_HIGH, 32'h12);
    win(0, 0, "buffered high");
    check("live before low", 16'hab00, count_o);
    bus(1, `ADR_COUNT_LOW, 32'h34);
    win(0, 0, "loaded hold");
    check("live after low", 16'h1234, count_o);
    rd(`ADR_COUNT_LOW, 32'h34, "wide low");
    rd(`ADR_COUNT_HIGH, 32'h12, "wide high");
    bus(1, `ADR_CONTROL, 32'h43);
    bus(1, `ADR_COUNT_HIGH, 32'h0);
    bus(1, `ADR_COUNT_LOW, 32'hf0);
    bus(0, `ADR_COUNT_LOW, 32'h0);
    c0 = {8'h0, rdata[7:0]};
    repeat (30) @(posedge clk_i);
    rd(`ADR_COUNT_HIGH, c0 < 16'hf0 ? 1 : 0, "latched high");
    $display("test wide access done");
    bus(1, `ADR_CONTROL, 32'h40);
    bus(1, `ADR_COUNT_HIGH, 32'hff);
    bus(1, `ADR_COUNT_LOW, 32'hf0);
    bus(1, `ADR_CONTROL, 32'h41);
    repeat (30) @(posedge clk_i);
    check("overflow flag", 1, ovf);
    rd(`ADR_STATUS, 32'h1, "status set");
    bus(1, `ADR_STATUS, 32'h1);
    rd(`ADR_STATUS, 32'h0, "status cleared");
    bus(1, `ADR_CONTROL, 32'h0);
    $display("test overflow done");
    win(0, 0, "osc idle");
    check("osc off", 0, osc_en);
    oth <= 1'b1;
    win(0, 0, "osc other");
    check("osc other", 1, osc_en);
    {oth, ssel} <= 3'b001;
    rd(`ADR_OSC_CONTROL, 32'h50, "osc running");
    check("osc select", 1, osc_en);
    ssel <= 2'h0;
    bus(1, `ADR_CONTROL, 32'h08);
    win(0, 0, "osc enable");
    check("osc enable bit", 1, osc_en);
    bus(1, `ADR_CONTROL, 32'h0);
    bus(1, `ADR_OSC_CONTROL, 32'h18);
    win(0, 0, "osc warmup");
    check("osc warmup", 1, osc_en);
    mstb <= 1'b1;
    bus(1, `ADR_OSC_CONTROL, 32'h01);
    rd(`ADR_OSC_CONTROL, 32'h03, "osc medium");
    check("drive low", 0, drv);
    check("substitute", 1, sub);
    check("osc released", 0, osc_en);
    $display("test oscillator done");
    report_and_stop;
  end
endmodule
